// File: verilog/dspi_pkg.sv
/*
  constants, mode enumeration and step helpers for the dac serial/pulse front end.
  assumes the counter is eight bits wide and that software reaches no registers.
*/
package dspi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and values after reset
  localparam int dspi_w = 8;
  localparam logic [7:0] dspi_preset = 8'h80;
  localparam logic [1:0] dspi_boot_cyc = 2'h3;
  localparam logic dspi_cs_idle = 1'h1;
  localparam logic dspi_sdi_idle = 1'h1;
  localparam logic dspi_shutdown_n_idle = 1'h1;
  localparam logic [7:0] dspi_off_code = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // counter control modes, boot is the short wait before the straps are read
  typedef enum logic [1:0] {
    md_boot,
    md_pulse_inc,
    md_pulse_updn,
    md_spi
  } dspi_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // increment-only step: upper six bits count, two lsbs forced low
  function automatic logic [7:0] dspi_step_inc(input logic [7:0] c);
    logic [5:0] up;
    up = c[7:2] + 6'h01;
    return {up, 2'h0};
  endfunction

  // increment/decrement step over the full eight bits
  function automatic logic [7:0] dspi_step_updn(input logic [7:0] c, input logic up);
    return up ? c + 8'h01 : c - 8'h01;
  endfunction

endpackage

// File: verilog/dspi_sync.sv
/*
  two flip-flop synchroniser for a group of levels.
  assumes each bit changes slowly against clk; rst is synchronous to clk.
*/
`timescale 1ns/10ps
module dspi_sync #(
  parameter int w = 1,
  parameter logic [w-1:0] init = '0
) (
  input wire logic clk,          // destination clock
  input wire logic rst,          // synchronous reset, high
  input wire logic [w-1:0] d,    // asynchronous levels
  output logic [w-1:0] q         // synchronised levels
);

  typedef struct packed {
    logic [w-1:0] meta;
    logic [w-1:0] sync;
  } dspi_sync_t;

  dspi_sync_t s;
  dspi_sync_t next_s;

  // first stage only feeds the second
  always_comb begin
    next_s = s;
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= {init, init};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

// File: verilog/dspi_link.sv
/*
  logic on the host serial clock: input shift register, pulse toggle, direction
  capture and the falling-edge data output.
  assumes cs_n and sdi are launched by the host against its own clock.
*/
`timescale 1ns/10ps
module dspi_link
  import dspi_pkg::*;
(
  input wire logic sclk,             // host serial clock
  input wire logic rst,              // system reset, crossed here
  input wire logic cs_n,             // chip select, low selects
  input wire logic sdi,              // serial data or count direction
  output logic [7:0] rx_byte,        // shifted byte, stable while cs_n high
  output logic pulse_tgl,            // toggles on each rising edge while cs_n high
  output logic dir,                  // sdi captured with the toggle
  output logic sdo                   // serial data out, msb first
);

  typedef struct packed {
    logic [7:0] rx;
    logic tgl;
    logic dir;
  } dspi_link_t;

  dspi_link_t s;
  dspi_link_t next_s;
  logic rst_l;
  logic sdo_q;

  // reset brought onto the serial clock
  dspi_sync #(.w(1), .init(1'h1)) u_rst_sync (
    .clk (sclk),
    .rst (1'h0),
    .d   (rst),
    .q   (rst_l)
  );

  ////////////////////////////////////////////////////////////////////////////
  // rising edge: shift in while selected, else count a pulse
  always_comb begin
    next_s = s;
    if (!cs_n) begin
      next_s.rx = {s.rx[6:0], sdi};
    end else begin
      next_s.tgl = ~s.tgl;
      next_s.dir = sdi;
    end
  end

  always_ff @(posedge sclk) begin
    if (rst_l) begin
      s <= '{rx: dspi_preset, tgl: 1'h0, dir: 1'h1};
    end else begin
      s <= next_s;
    end
  end

  // falling edge: the old msb moves out; a fall while in reset loads bit 7 of dspi_preset
  always_ff @(negedge sclk) begin
    if (rst_l) begin
      sdo_q <= dspi_preset[7];
    end else begin
      sdo_q <= s.rx[7];
    end
  end

  assign rx_byte = s.rx;
  assign pulse_tgl = s.tgl;
  assign dir = s.dir;
  assign sdo = sdo_q;

  chk_shift_in: assert property (@(posedge sclk) disable iff (rst_l)
    !cs_n |=> s.rx[0] == $past(sdi) && s.rx[7:1] == $past(s.rx[6:0]))
    else $error("serial bit not shifted in");

endmodule

// File: verilog/dspi_top.sv
/*
  digital front end of the 8-bit current dac: mode straps, serial load,
  pulse counting, shutdown hold and the three-state data output.
  assumes sclk comes from the host and runs while rst is held; all pins
  other than rst are asynchronous to sys_clk.
*/
`timescale 1ns/10ps

// How it works
// - host sends one bit per clock, each rising edge while chip select is low shifts it in.
// - data output stays off until chip select goes low, then drives.
// - while selected, the old byte goes out one bit per falling edge.
// - chip select rising loads the shifted byte into the counter and output.
// - data output turns off at select rising; always off in pulse mode.
// - chip select high at power-up gives pulse mode.
// - any low on chip select gives serial mode until reset.
// - data-in high at power-up in pulse mode gives increment-only counting.
// - direction pin low once gives up/down counting until reset or chip select low.
// - pulse mode steps the counter once per rising clock edge.
// - serial words are taken only while chip select is low.
// - shutdown holds the counter; release restores the held output.
// - reset presets the counter to 80h, mid-range.
// - serial data moves msb first both ways.
// - increment-only adds one to upper six bits, wraps past fch to 00h.
module dspi_top
  import dspi_pkg::*;
(
  input wire logic sys_clk,                   // system clock, 125 mhz
  input wire logic rst,                       // synchronous reset, high
  input wire logic sclk,                      // host serial clock
  input wire logic cs_n,                      // chip select, low selects
  input wire logic sdi,                       // serial data in / count direction
  input wire logic shutdown_n,                // low holds the dac off
  output logic sdo,                           // serial data out
  output logic sdo_oe,                        // high while sdo is driven
  output logic [dspi_w-1:0] dac_current_out,  // code fed to the current dac
  output logic spi_mode,                      // serial mode latched
  output logic updn_mode                      // up/down pulse mode latched
);

  typedef struct packed {
    dspi_mode_t mode;
    logic [1:0] boot;
    logic [7:0] counter;
    logic [7:0] dac_out;
    logic oe;
    logic cs_d;
    logic tgl_d;
  } dspi_top_t;

  dspi_top_t s;
  dspi_top_t next_s;

  logic [7:0] rx_byte;
  logic [7:0] rx_s;
  logic pulse_tgl;
  logic dir;
  logic tgl_s;
  logic dir_s;
  logic cs_s;
  logic sdi_s;
  logic shutdown_n_s;
  logic step;
  logic cs_rise;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock side
  dspi_link u_link (
    .sclk      (sclk),
    .rst       (rst),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .rx_byte   (rx_byte),
    .pulse_tgl (pulse_tgl),
    .dir       (dir),
    .sdo       (sdo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // crossings into sys_clk
  dspi_sync #(.w(3), .init({dspi_cs_idle, dspi_sdi_idle, dspi_shutdown_n_idle})) u_pin_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   ({cs_n, sdi, shutdown_n}),
    .q   ({cs_s, sdi_s, shutdown_n_s})
  );

  // toggle marks the event, direction was captured with it
  dspi_sync #(.w(2), .init(2'h1)) u_step_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   ({pulse_tgl, dir}),
    .q   ({tgl_s, dir_s})
  );

  // byte is quiet while cs_n is high, the select edge marks it
  dspi_sync #(.w(8), .init(dspi_preset)) u_byte_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (rx_byte),
    .q   (rx_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  assign step = tgl_s ^ s.tgl_d;
  assign cs_rise = cs_s & ~s.cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: mode straps, counter, output enable
  always_comb begin
    next_s = s;
    next_s.cs_d = cs_s;
    next_s.tgl_d = tgl_s;
    case (s.mode)
      md_boot: begin
        if (s.boot == dspi_boot_cyc) begin
          if (!cs_s) begin
            next_s.mode = md_spi;
          end else if (sdi_s) begin
            next_s.mode = md_pulse_inc;
          end else begin
            next_s.mode = md_pulse_updn;
          end
        end else begin
          next_s.boot = s.boot + 2'h1;
        end
      end
      md_pulse_inc: begin
        if (!cs_s) begin
          next_s.mode = md_spi;
        end else begin
          if (!sdi_s) begin
            next_s.mode = md_pulse_updn;
          end
          if (step && shutdown_n_s) begin
            next_s.counter = dspi_step_inc(s.counter);
          end
        end
      end
      md_pulse_updn: begin
        if (!cs_s) begin
          next_s.mode = md_spi;
        end else if (step && shutdown_n_s) begin
          next_s.counter = dspi_step_updn(s.counter, dir_s);
        end
      end
      md_spi: begin
        if (cs_rise && shutdown_n_s) begin
          next_s.counter = rx_s;
        end
      end
      default: begin
        next_s.mode = md_boot;
      end
    endcase
    // drive only once straps are read and select is low
    next_s.oe = (s.mode != md_boot) && !cs_s;
    // shutdown forces zero current but keeps the counter
    next_s.dac_out = shutdown_n_s ? next_s.counter : dspi_off_code;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{mode: md_boot, boot: 2'h0, counter: dspi_preset, dac_out: dspi_preset,
             oe: 1'h0, cs_d: dspi_cs_idle, tgl_d: 1'h0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sdo_oe = s.oe;
  assign dac_current_out = s.dac_out;
  assign spi_mode = (s.mode == md_spi);
  assign updn_mode = (s.mode == md_pulse_updn);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_preset_counter: assert property (@(posedge sys_clk)
    $past(rst) && !rst |-> s.counter == dspi_preset && s.mode == md_boot)
    else $error("counter not preset after reset");

  chk_oe_pulse_off: assert property (@(posedge sys_clk) disable iff (rst)
    (s.mode == md_pulse_inc || s.mode == md_pulse_updn || s.mode == md_boot) |-> !sdo_oe)
    else $error("data output driven outside serial mode");

  chk_oe_select_on: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_spi && !cs_s |=> sdo_oe)
    else $error("data output not driven while selected");

  chk_oe_release_off: assert property (@(posedge sys_clk) disable iff (rst)
    cs_s |=> !sdo_oe)
    else $error("data output still driven after deselect");

  chk_spi_mode_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_spi |=> s.mode == md_spi)
    else $error("serial mode left before reset");

  chk_select_enters_spi: assert property (@(posedge sys_clk) disable iff (rst)
    (s.mode == md_pulse_inc || s.mode == md_pulse_updn) && !cs_s |=> s.mode == md_spi)
    else $error("select low did not enter serial mode");

  chk_strap_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot && s.boot == dspi_boot_cyc && cs_s && sdi_s |=> s.mode == md_pulse_inc)
    else $error("high straps did not give increment-only");

  chk_updn_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_updn |=> s.mode == md_pulse_updn || s.mode == md_spi)
    else $error("up/down mode lost");

  chk_load_byte: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_spi && cs_rise && shutdown_n_s |=> s.counter == $past(rx_s) ##1 dac_current_out == s.counter)
    else $error("byte not loaded at deselect");

  chk_inc_only_step: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_inc && cs_s && step && shutdown_n_s
    |=> s.counter[1:0] == 2'h0 && s.counter[7:2] == $past(s.counter[7:2]) + 6'h01)
    else $error("increment-only step wrong");

  chk_updn_step: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_updn && cs_s && step && shutdown_n_s
    |=> s.counter == ($past(dir_s) ? $past(s.counter) + 8'h01 : $past(s.counter) - 8'h01))
    else $error("up/down step wrong");

  chk_shutdown_n_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !shutdown_n_s ##1 !shutdown_n_s |-> $stable(s.counter) && dac_current_out == dspi_off_code)
    else $error("counter moved or current on in shutdown");

  // a step in the release cycle is shown at once, so compare with the live counter
  chk_shutdown_n_restore: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(shutdown_n_s) |=> dac_current_out == s.counter)
    else $error("current not restored after shutdown");

  ////////////////////////////////////////////////////////////////////////////
  // strap wait, mode moves, counter holds and the current code
  chk_boot_count: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot && s.boot != dspi_boot_cyc |=> s.mode == md_boot && s.boot == $past(s.boot) + 2'h1)
    else $error("strap wait did not count");

  chk_boot_leaves: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot && s.boot == dspi_boot_cyc |=> s.mode != md_boot)
    else $error("straps not read after the wait");

  chk_strap_updn: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot && s.boot == dspi_boot_cyc && cs_s && !sdi_s |=> s.mode == md_pulse_updn)
    else $error("low direction strap did not give up/down");

  chk_boot_no_oe: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot |=> !sdo_oe)
    else $error("data output driven before straps read");

  chk_oe_needs_spi: assert property (@(posedge sys_clk) disable iff (rst)
    sdo_oe |-> s.mode == md_spi)
    else $error("data output driven outside serial mode");

  chk_boot_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_boot |=> $stable(s.counter))
    else $error("counter moved during strap wait");

  chk_inc_holds: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_inc && cs_s && sdi_s |=> s.mode == md_pulse_inc)
    else $error("increment-only mode left without cause");

  chk_inc_to_updn: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_inc && cs_s && !sdi_s |=> s.mode == md_pulse_updn)
    else $error("direction low did not give up/down");

  chk_pulse_no_spi: assert property (@(posedge sys_clk) disable iff (rst)
    (s.mode == md_pulse_inc || s.mode == md_pulse_updn) && cs_s |=> s.mode != md_spi)
    else $error("serial mode entered without select");

  chk_inc_lsbs_zero: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_inc |-> s.counter[1:0] == 2'h0)
    else $error("low bits set in increment-only mode");

  chk_inc_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_pulse_inc && cs_s && step && shutdown_n_s && s.counter == 8'hfc |=> s.counter == 8'h00)
    else $error("increment-only did not wrap to zero");

  chk_pulse_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (s.mode == md_pulse_inc || s.mode == md_pulse_updn) && !step |=> $stable(s.counter))
    else $error("counter moved without a pulse");

  chk_spi_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s.mode == md_spi && !cs_rise |=> $stable(s.counter))
    else $error("counter moved without deselect");

  chk_shutdown_n_freeze: assert property (@(posedge sys_clk) disable iff (rst)
    !shutdown_n_s |=> $stable(s.counter))
    else $error("counter moved in shutdown");

  chk_dac_follows: assert property (@(posedge sys_clk) disable iff (rst)
    shutdown_n_s |=> dac_current_out == s.counter)
    else $error("current code does not follow counter");

  chk_dac_off: assert property (@(posedge sys_clk) disable iff (rst)
    !shutdown_n_s |=> dac_current_out == dspi_off_code)
    else $error("current code not off in shutdown");

endmodule

// File: dv/dspi_host.sv
/*
  host controller model: serial frames and clock pulses on the dac pins.
  assumes sdo_w is the resolved data-out wire; timing is in ns.
*/
`timescale 1ns/10ps
module dspi_host (
  output logic sclk,     // serial clock, idles low
  output logic cs_n,     // chip select
  output logic sdi,      // data in or direction
  input wire logic sdo_w // resolved data out
);
  ////////////////////////////////////////////////////////////////////////////
  // idle levels pick pulse, increment-only
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi = 1'h1;
  end

  // free clocking while reset is held
  task automatic run_clk(input int n);
    repeat (n) begin
      #80 sclk = 1'h1;
      #80 sclk = 1'h0;
    end
  endtask

  // one count pulse, direction set up before the rise
  task automatic pulse(input logic d);
    sdi = d;
    #80 sclk = 1'h1;
    #80 sclk = 1'h0;
  endtask

  // one byte msb first, old byte read before each rise
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    cs_n = 1'h0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #80 rx[i] = sdo_w;
      sclk = 1'h1;
      #80 sclk = 1'h0;
    end
    #160 cs_n = 1'h1;
    #480;
  endtask
endmodule

// File: dv/dspi_top_tb_top.sv
/*
  self-checking bench for the dac front end: pulse modes, shutdown, serial frames.
  assumes the host model drives all link pins; sdo is resolved here.
*/
`timescale 1ns/10ps
module dspi_top_tb_top;
  import dspi_pkg::*;
  logic sys_clk, rst, shutdown_n, sdo, sdo_oe, spi_mode, updn_mode, sdo_last, sdo_w;
  logic sclk, cs_n, sdi;
  logic [7:0] dac_current_out, cnt, tx, prev, rx;
  int num_errors, checks_done, seed;

  ////////////////////////////////////////////////////////////////////////////
  // clock and three-state resolution of data out
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (sdo_oe === 1'h1) sdo_last <= sdo;
  assign sdo_w = (sdo_oe === 1'h1) ? sdo : ~sdo_last;

  dspi_top dspi_top_i (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .shutdown_n(shutdown_n), .sdo(sdo), .sdo_oe(sdo_oe), .dac_current_out(dac_current_out),
    .spi_mode(spi_mode), .updn_mode(updn_mode));
  dspi_host dspi_host_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_w(sdo_w));

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and expected steps
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [7:0] inc6(input logic [7:0] c);
    return {c[7:2] + 6'h01, 2'h0};
  endfunction

  // reset with the host clock running, then let the straps settle
  task automatic do_reset(input logic s);
    dspi_host_i.sdi = s;
    @(posedge sys_clk) #1 rst = 1'h1;
    fork
      dspi_host_i.run_clk(6);
      repeat (8) @(posedge sys_clk);
    join
    @(posedge sys_clk) #1 rst = 1'h0;
    // the link leaves reset only after two more serial clock rises
    dspi_host_i.run_clk(2);
    repeat (10) @(posedge sys_clk);
    #1 check("preset", dac_current_out, 8'h80);
    check("spi_mode", {7'h0, spi_mode}, 8'h00);
    check("updn", {7'h0, updn_mode}, {7'h0, ~s});
  endtask

  task automatic settle();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #600000;
    num_errors++;
    results();
  end

  // main sequence
  initial begin
    rst = 1'h1;
    shutdown_n = 1'h1;
    num_errors = 0;
    checks_done = 0;
    seed = 32'h18af;
    do_reset(1'h1);
    cnt = 8'h80;
    for (int i = 0; i < 34; i++) begin
      dspi_host_i.pulse(1'h1);
      settle();
      cnt = inc6(cnt);
      check("inc", dac_current_out, cnt);
      check("oe_pulse", {7'h0, sdo_oe}, 8'h00);
    end
    dspi_host_i.pulse(1'h0);
    settle();
    check("updn_on", {7'h0, updn_mode}, 8'h01);
    do_reset(1'h0);
    cnt = 8'h80;
    for (int i = 0; i < 40; i++) begin
      tx[0] = (i < 4) ? 1'h0 : 1'($random(seed));
      if (i == 20) begin
        @(posedge sys_clk) #1 shutdown_n = 1'h0;
        settle();
        check("shutdown_n", dac_current_out, dspi_off_code);
      end
      dspi_host_i.pulse(tx[0]);
      settle();
      if (i == 20) begin
        @(posedge sys_clk) #1 shutdown_n = 1'h1;
        settle();
      end else
        cnt = tx[0] ? cnt + 8'h01 : cnt - 8'h01;
      check("updn", dac_current_out, cnt);
    end
    prev = dspi_preset;
    for (int i = 0; i < 12; i++) begin
      tx = (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($random(seed));
      fork
        dspi_host_i.frame(tx, rx);
        begin
          #600 check("oe_on", {7'h0, sdo_oe}, 8'h01);
        end
      join
      settle();
      check("sdo", rx, prev);
      check("load", dac_current_out, tx);
      check("oe_off", {7'h0, sdo_oe}, 8'h00);
      check("spi_on", {7'h0, spi_mode}, 8'h01);
      prev = tx;
    end
    results();
  end
endmodule
